/* design/ldr_pkg.sv */
// Shared constants, types and register map of the LVDS deserializer control
package ldr_pkg;

   localparam int CLK_PERIOD_NS = 40;
   localparam int SLOTS         = 9;
   localparam int DATA_BITS     = 7;
   localparam int CHANNELS      = 3;
   localparam int OUT_BITS      = CHANNELS * DATA_BITS;
   localparam int SYNC_W        = 2 * CHANNELS + 2;

   // Slowest acceptable link period; longer means clock lost or too slow
   localparam int LOSS_NS       = 2000;
   localparam int LOSS_CYCLES   = LOSS_NS / CLK_PERIOD_NS;
   localparam int LOCK_PERIODS  = 32800;
   localparam int FREQ_TOL      = 1;

   localparam int CNT_W         = 8;
   localparam int TGT_W         = 12;
   localparam int LOCK_W        = 16;
   localparam int ERR_W         = 16;

   localparam logic [31:0] CTRL_OFFSET   = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
   localparam logic [31:0] PERIOD_OFFSET = 32'h0000_0008;
   localparam logic [31:0] ERRCNT_OFFSET = 32'h0000_000c;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam int CTRL_FALLING_BIT = 0;
   localparam int STAT_STATE_LSB   = 0;
   localparam int STAT_CLK_OK_BIT  = 2;
   localparam int STAT_LOCKED_BIT  = 3;
   localparam int STAT_NEG_LSB     = 4;

   // Flag pair as {slot 7, slot 8}
   localparam logic [1:0] FLAG_INVERTED = 2'h2;

   typedef enum logic [1:0] {
      ST_SLEEP  = 2'h0,
      ST_ACQ    = 2'h1,
      ST_LOCKED = 2'h3
   } ldr_state_t;

   typedef struct packed {
      logic [DATA_BITS-1:0] data;
      logic                 flag_err;
      logic                 static_neg;
   } ldr_word_t;

endpackage

/* design/ldr_sync.sv */
// Two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/10ps
`default_nettype none
module ldr_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         meta <= '0;
         o_q  <= '0;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule
`default_nettype wire

/* design/ldr_chan.sv */
// One serial channel: collects nine slots and removes the inversion coding
`timescale 1ns/10ps
`default_nettype none
module ldr_chan (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_start,
   input  wire logic        i_sample,
   input  wire logic        i_last,
   input  wire logic        i_pos,
   input  wire logic        i_neg,
   output var  ldr_pkg::ldr_word_t o_word,
   output logic             o_done
);
   import ldr_pkg::*;

   logic [SLOTS-1:0] bits;
   logic [SLOTS-1:0] next_bits;
   logic [SLOTS-1:0] full;
   logic             all_neg;
   logic             next_all_neg;
   logic             inv;
   ldr_word_t        next_word;
   logic             next_done;

   always_comb begin
      next_bits    = bits;
      next_all_neg = all_neg;
      next_word    = o_word;
      next_done    = 1'b0;
      full         = bits;
      inv          = 1'b0;
      // Closing a cut word may share the cycle that opens the next one
      if (i_sample) begin
         // Slot 0 ends up in bit 0 after nine shifts
         full         = {i_pos & ~i_neg, bits[SLOTS-1:1]};
         next_bits    = full;
         next_all_neg = all_neg & ~i_pos & i_neg;
         if (i_last) begin
            inv = ({full[DATA_BITS], full[DATA_BITS+1]} == FLAG_INVERTED);
            next_word.flag_err   = (full[DATA_BITS] == full[DATA_BITS+1]);
            next_word.static_neg = next_all_neg;
            if (next_all_neg) begin
               next_word.data = '0;
            end else if (inv) begin
               next_word.data = ~full[DATA_BITS-1:0];
            end else begin
               next_word.data = full[DATA_BITS-1:0];
            end
            next_done = 1'b1;
         end
      end
      if (i_start) begin
         next_bits    = '0;
         next_all_neg = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         bits    <= '0;
         all_neg <= 1'b0;
         o_word  <= '0;
         o_done  <= 1'b0;
      end else begin
         bits    <= next_bits;
         all_neg <= next_all_neg;
         o_word  <= next_word;
         o_done  <= next_done;
      end
   end
endmodule
`default_nettype wire

/* design/ldr_deser.sv */
// Receive-side control of a three-channel DC-balanced LVDS deserializer
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ldr_deser #(
   parameter int P_LOCK_PERIODS = ldr_pkg::LOCK_PERIODS
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_srst,
   input  wire logic                         i_lvds_clock_input,
   input  wire logic [ldr_pkg::CHANNELS-1:0] i_lvds_serial_data_input_p,
   input  wire logic [ldr_pkg::CHANNELS-1:0] i_lvds_serial_data_input_n,
   input  wire logic                         i_output_enable_sleep_n,
   output logic      [ldr_pkg::OUT_BITS-1:0] o_parallel_data_output,
   output logic      [ldr_pkg::OUT_BITS-1:0] o_parallel_data_oe_n,
   output logic                              o_parallel_strobe_output,
   output logic                              o_parallel_strobe_oe_n,
   input  wire logic                         i_hsel,
   input  wire logic [31:0]                  i_haddr,
   input  wire logic [1:0]                   i_htrans,
   input  wire logic                         i_hwrite,
   input  wire logic [2:0]                   i_hsize,
   input  wire logic [31:0]                  i_hwdata,
   input  wire logic                         i_hready,
   output logic                              o_hreadyout,
   output logic                              o_hresp,
   output logic      [31:0]                  o_hrdata
);
   import ldr_pkg::*;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and link clock edge

   logic [SYNC_W-1:0]   sync_q;
   logic                sleep_s;
   logic                lclk_s;
   logic [CHANNELS-1:0] pos_s;
   logic [CHANNELS-1:0] neg_s;
   logic                lclk_d;
   logic                le;

   ldr_sync #(.W(SYNC_W)) u_sync (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .i_d    ({i_output_enable_sleep_n, i_lvds_clock_input,
                i_lvds_serial_data_input_p, i_lvds_serial_data_input_n}),
      .o_q    (sync_q)
   );

   assign {sleep_s, lclk_s, pos_s, neg_s} = sync_q;
   assign le = lclk_s & ~lclk_d;

   ////////////////////////////////////////////////////////////////////////
   // Link period measurement, loss detection and slot sampling

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [CNT_W-1:0] period;
   logic [CNT_W-1:0] next_period;
   logic [CNT_W-1:0] meas;
   logic             clk_ok;
   logic             next_clk_ok;
   logic [3:0]       slot;
   logic [3:0]       next_slot;
   logic [TGT_W-1:0] target;
   logic [TGT_W-1:0] next_target;
   logic [TGT_W-1:0] acc;
   logic             clk_lost;
   logic             fchg;
   logic             sample;
   logic             last;

   always_comb begin
      meas        = cnt + CNT_W'(1);
      acc         = TGT_W'(cnt) * TGT_W'(2 * SLOTS);
      clk_lost    = (cnt == CNT_W'(LOSS_CYCLES - 1)) && !le;
      fchg        = le && clk_ok &&
                    ((meas > period + CNT_W'(FREQ_TOL)) ||
                     (meas + CNT_W'(FREQ_TOL) < period));
      // Slot k is taken at the middle of its ninth of the period
      // A period too short for nine samples closes its word at the next edge
      sample      = clk_ok && (slot < 4'(SLOTS)) &&
                    (le || (acc >= target));
      last        = sample && (le || (slot == 4'(SLOTS - 1)));
      next_cnt    = cnt;
      next_period = period;
      next_clk_ok = clk_ok;
      next_slot   = slot;
      next_target = target;
      if (le) begin
         next_cnt    = '0;
         next_period = meas;
         next_clk_ok = 1'b1;
         next_slot   = '0;
         next_target = TGT_W'(meas);
      end else begin
         if (clk_lost) begin
            next_clk_ok = 1'b0;
         end else begin
            next_cnt = cnt + CNT_W'(1);
         end
         if (sample) begin
            next_slot   = slot + 4'h1;
            next_target = target + TGT_W'({period, 1'b0});
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         lclk_d <= 1'b0;
         cnt    <= '0;
         period <= '0;
         clk_ok <= 1'b0;
         slot   <= '0;
         target <= '0;
      end else begin
         lclk_d <= lclk_s;
         cnt    <= next_cnt;
         period <= next_period;
         clk_ok <= next_clk_ok;
         slot   <= next_slot;
         target <= next_target;
      end
   end

   AST_NINE_SLOTS: assert property (
      le && clk_ok && slot != 4'(SLOTS) |=> done[0])
      else $error("word cut short by the link edge was not closed");

   ////////////////////////////////////////////////////////////////////////
   // Channel decoders, balanced coding only

   ldr_word_t           word [CHANNELS];
   logic [CHANNELS-1:0] done;

   genvar gc;
   generate
      for (gc = 0; gc < CHANNELS; gc++) begin : g_chan
         ldr_chan u_chan (
            .i_clk    (i_clk),
            .i_srst   (i_srst),
            .i_start  (le),
            .i_sample (sample),
            .i_last   (last),
            .i_pos    (pos_s[gc]),
            .i_neg    (neg_s[gc]),
            .o_word   (word[gc]),
            .o_done   (done[gc])
         );
      end
   endgenerate

   AST_STATIC_NEG: assert property (
      done[0] && word[0].static_neg |-> word[0].data == '0)
      else $error("static negative channel produced data");

   ////////////////////////////////////////////////////////////////////////
   // Sleep, lock acquisition and state

   ldr_state_t        state;
   ldr_state_t        next_state;
   logic [LOCK_W-1:0] lock_cnt;
   logic [LOCK_W-1:0] next_lock_cnt;
   logic              relock;
   logic              locked;

   assign relock = clk_lost | fchg;
   assign locked = (state == ST_LOCKED);

   always_comb begin
      next_state    = state;
      next_lock_cnt = lock_cnt;
      case (state)
         ST_SLEEP: begin
            next_lock_cnt = '0;
            if (sleep_s) begin
               next_state = ST_ACQ;
            end
         end
         ST_ACQ: begin
            if (relock) begin
               next_lock_cnt = '0;
            end else if (le) begin
               if (lock_cnt == LOCK_W'(P_LOCK_PERIODS - 1)) begin
                  next_state    = ST_LOCKED;
                  next_lock_cnt = '0;
               end else begin
                  next_lock_cnt = lock_cnt + LOCK_W'(1);
               end
            end
         end
         ST_LOCKED: begin
            if (relock) begin
               next_state    = ST_ACQ;
               next_lock_cnt = '0;
            end
         end
         default: begin
            next_state    = ST_SLEEP;
            next_lock_cnt = '0;
         end
      endcase
      if (!sleep_s) begin
         next_state    = ST_SLEEP;
         next_lock_cnt = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state    <= ST_SLEEP;
         lock_cnt <= '0;
      end else begin
         state    <= next_state;
         lock_cnt <= next_lock_cnt;
      end
   end

   sequence seq_relock;
      clk_lost && sleep_s ##1 (lock_cnt == '0);
   endsequence

   AST_LOSS_CLEARS_LOCK: assert property (
      clk_lost && sleep_s && state != ST_SLEEP |-> seq_relock)
      else $error("clock loss did not clear the lock counter");

   AST_LOCK_COUNT: assert property (
      $rose(locked) |-> $past(lock_cnt) == LOCK_W'(P_LOCK_PERIODS - 1))
      else $error("lock declared at the wrong period count");

   AST_SLEEP_ENTRY: assert property (!sleep_s |=> state == ST_SLEEP)
      else $error("sleep input did not halt the lock machine");

   ////////////////////////////////////////////////////////////////////////
   // Parallel outputs and strobe

   logic [OUT_BITS-1:0] data_q;
   logic [OUT_BITS-1:0] next_data;
   logic [OUT_BITS-1:0] dec;
   logic [CNT_W-1:0]    ph_cnt;
   logic [CNT_W-1:0]    next_ph_cnt;
   logic                strobe;
   logic                next_strobe;
   logic                falling;
   logic [CHANNELS-1:0] neg_flags;
   logic [CHANNELS-1:0] next_neg_flags;

   assign dec = {word[2].data, word[1].data, word[0].data};

   always_comb begin
      next_data      = data_q;
      next_ph_cnt    = ph_cnt;
      next_neg_flags = neg_flags;
      if (ph_cnt != {CNT_W{1'b1}}) begin
         next_ph_cnt = ph_cnt + CNT_W'(1);
      end
      if (done[0]) begin
         next_ph_cnt    = '0;
         next_neg_flags = {word[2].static_neg, word[1].static_neg,
                           word[0].static_neg};
      end
      if (!locked || clk_lost) begin
         next_data = '0;
      end else if (done[0]) begin
         next_data = dec;
      end
      // Data changes in the low half for rising strobe, high half for falling
      if (locked) begin
         next_strobe = (ph_cnt >= (period >> 1)) ^ falling;
      end else begin
         next_strobe = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         data_q    <= '0;
         ph_cnt    <= '0;
         strobe    <= 1'b0;
         neg_flags <= '0;
      end else begin
         data_q    <= next_data;
         ph_cnt    <= next_ph_cnt;
         strobe    <= next_strobe;
         neg_flags <= next_neg_flags;
      end
   end

   // Pins float only in sleep; the sharing gap is left to the system
   assign o_parallel_data_output   = data_q;
   assign o_parallel_strobe_output = strobe;
   assign o_parallel_data_oe_n     = {OUT_BITS{state == ST_SLEEP}};
   assign o_parallel_strobe_oe_n   = (state == ST_SLEEP);

   AST_SLEEP_HIZ: assert property (state == ST_SLEEP |->
      (&o_parallel_data_oe_n) && o_parallel_strobe_oe_n)
      else $error("outputs driven while asleep");

   AST_LOW_UNTIL_LOCK: assert property (!locked |=>
      o_parallel_data_output == '0 && !o_parallel_strobe_output)
      else $error("outputs not low before lock");

   AST_LOSS_LOW: assert property (clk_lost |=>
      o_parallel_data_output == '0)
      else $error("outputs not low after clock loss");

   AST_WORD_UPDATE: assert property (locked && !clk_lost && done[0] |=>
      o_parallel_data_output == $past(dec))
      else $error("decoded word not presented");

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite register slave: zero wait states, always OKAY

   logic [31:0]      ctrl;
   logic [31:0]      next_ctrl;
   logic [ERR_W-1:0] errcnt;
   logic [ERR_W-1:0] next_errcnt;
   logic [ERR_W-1:0] err_inc;
   logic [31:0]      addr_q;
   logic [31:0]      next_addr_q;
   logic             wr_q;
   logic             next_wr_q;
   logic [31:0]      next_rdata;
   logic [31:0]      rd_val;
   logic             take;

   assign take    = i_hsel && i_htrans[1] && i_hready;
   assign falling = ctrl[CTRL_FALLING_BIT];
   assign err_inc = done[0] ? ERR_W'(word[0].flag_err) + ERR_W'(word[1].flag_err)
                            + ERR_W'(word[2].flag_err) : '0;

   always_comb begin
      if (i_haddr == CTRL_OFFSET) begin
         rd_val = ctrl;
      end else if (i_haddr == STATUS_OFFSET) begin
         rd_val = 32'(neg_flags) << STAT_NEG_LSB;
         rd_val[STAT_STATE_LSB +: 2] = state;
         rd_val[STAT_CLK_OK_BIT]     = clk_ok;
         rd_val[STAT_LOCKED_BIT]     = locked;
      end else if (i_haddr == PERIOD_OFFSET) begin
         rd_val = 32'(period);
      end else if (i_haddr == ERRCNT_OFFSET) begin
         rd_val = 32'(errcnt);
      end else begin
         rd_val = '0;
      end
      next_rdata  = (take && !i_hwrite) ? rd_val : o_hrdata;
      next_addr_q = take ? i_haddr : addr_q;
      next_wr_q   = take && i_hwrite;
      next_ctrl   = ctrl;
      next_errcnt = errcnt + err_inc;
      if (wr_q) begin
         if (addr_q == CTRL_OFFSET) begin
            next_ctrl = i_hwdata;
         end else if (addr_q == ERRCNT_OFFSET) begin
            next_errcnt = err_inc;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ctrl     <= CTRL_RESET;
         errcnt   <= '0;
         addr_q   <= '0;
         wr_q     <= 1'b0;
         o_hrdata <= '0;
      end else begin
         ctrl     <= next_ctrl;
         errcnt   <= next_errcnt;
         addr_q   <= next_addr_q;
         wr_q     <= next_wr_q;
         o_hrdata <= next_rdata;
      end
   end

   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

endmodule
`default_nettype wire

/* bench/ldr_ser_model.sv */
// Behavioural far-end serializer: link clock plus three coded lanes
`timescale 1ns/10ps
`default_nettype none
module ldr_ser_model (
   input  wire logic       i_run,
   input  wire logic [2:0] i_hold_neg,
   input  var  int         i_period_ns,
   output logic            o_clk,
   output logic [2:0]      o_p,
   output logic [2:0]      o_n
);
   logic [6:0] word;
   logic [6:0] d;
   logic [8:0] sym [3];
   logic       long_hi;
   real        t0;
   initial begin
      o_clk = 1'b0;
      o_p = 3'h0;
      o_n = 3'h7;
      word = 7'h00;
      long_hi = 1'b0;
      forever begin
         // Clock stands still when stopped; lanes keep toggling
         while (!i_run) begin
            o_p = ~o_p;
            o_n = ~o_p;
            #37.3;
         end
         for (int c = 0; c < 3; c++) begin
            d = word + 7'(c * 37);
            if ($countones(d) > 3) sym[c] = {2'b01, ~d};
            else sym[c] = {2'b10, d};
         end
         // Slot times from word start, so the period never drifts
         t0 = $realtime;
         for (int k = 0; k < 9; k++) begin
            o_clk = (k < (long_hi ? 5 : 4));
            for (int c = 0; c < 3; c++) begin
               o_p[c] = i_hold_neg[c] ? 1'b0 : sym[c][k];
               o_n[c] = ~o_p[c];
            end
            #(t0 + (k + 1) * i_period_ns / 9.0 - $realtime);
         end
         long_hi = ~long_hi;
         word = word + 7'h01;
      end
   end
endmodule
`default_nettype wire

/* bench/ldr_deser_test.sv */
// Self-checking bench for the deserializer control block
`timescale 1ns/10ps
`default_nettype none
module ldr_deser_test;
   import ldr_pkg::*;
   localparam int LOCKS = 4;
   localparam int LIMIT = 4000;
   logic                clk, srst, sleep_n, run, link_clk;
   logic [2:0]          hold_neg, lp, ln;
   int                  period_ns;
   logic [OUT_BITS-1:0] pdata, poe_n;
   logic                strobe, strobe_oe_n;
   logic                hsel, hwrite, hready, hresp;
   logic [1:0]          htrans;
   logic [2:0]          hsize;
   logic [31:0]         haddr, hwdata, hrdata, rd;
   int                  n_mismatch, check_count, cyc, rises, changes;

   initial begin
      clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end

   ldr_ser_model far (.i_run(run), .i_hold_neg(hold_neg),
      .i_period_ns(period_ns), .o_clk(link_clk), .o_p(lp), .o_n(ln));

   ldr_deser #(.P_LOCK_PERIODS(LOCKS)) DUT (.i_clk(clk), .i_srst(srst),
      .i_lvds_clock_input(link_clk), .i_lvds_serial_data_input_p(lp),
      .i_lvds_serial_data_input_n(ln), .i_output_enable_sleep_n(sleep_n),
      .o_parallel_data_output(pdata), .o_parallel_data_oe_n(poe_n),
      .o_parallel_strobe_output(strobe),
      .o_parallel_strobe_oe_n(strobe_oe_n), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
      .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata));

   ////////////////////////////////////////////////////////////////////////
   always @(posedge strobe) rises++;
   always @(pdata) changes++;

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   // Polls the lock flag; a bounded number of reads
   task automatic poll(input logic want);
      int i;
      i = 0;
      do begin
         ahb(1'b0, STATUS_OFFSET, 32'h0);
         i++;
      end while (rd[STAT_LOCKED_BIT] !== want && i < 40);
   endtask

   task automatic cycles(input int k);
      repeat (k) @(negedge clk);
   endtask

   task automatic finish_test();
      if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      {srst, sleep_n, run, hold_neg, period_ns} =
         {1'b1, 1'b0, 1'b0, 3'h0, 32'h0000_0140};
      {hsel, hwrite, htrans, hsize, haddr, hwdata, rd} = {4'h0, 3'h2, 96'h0};
      {n_mismatch, check_count, cyc, rises, changes} = '0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      cycles(1);
      check("data oe_n", 32'(poe_n), 32'h001f_ffff);
      check("strobe oe_n", 32'(strobe_oe_n), 32'h1);
      ahb(1'b0, CTRL_OFFSET, 32'h0);
      check("ctrl", rd, CTRL_RESET);
      ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
      ahb(1'b0, 32'h0000_0010, 32'h0);
      check("unmapped", rd, 32'h0);
      check("hresp", 32'(hresp), 32'h0);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      check("status", 32'(rd[3:0]), 32'(ST_SLEEP));
      @(posedge clk);
      sleep_n <= 1'b1;
      cycles(6);
      check("data oe_n", 32'(poe_n), 32'h0);
      check("data", 32'(pdata), 32'h0);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      check("state", 32'(rd[1:0]), 32'(ST_ACQ));
      @(posedge clk);
      run <= 1'b1;
      repeat (16) begin
         cycles(1);
         check("acquire data", 32'(pdata), 32'h0);
      end
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      check("early lock", 32'(rd[STAT_LOCKED_BIT]), 32'h0);
      poll(1'b1);
      check("locked", 32'(rd[STAT_LOCKED_BIT]), 32'h1);
      ahb(1'b0, PERIOD_OFFSET, 32'h0);
      check("period", rd, 32'(320 / CLK_PERIOD_NS));
      {rises, changes} = '0;
      cycles(80);
      check("strobe", 32'(rises >= 9 && rises <= 11), 32'h1);
      check("updates", 32'(changes <= 11), 32'h1);
      check("strobe oe_n", 32'(strobe_oe_n), 32'h0);
      ahb(1'b1, CTRL_OFFSET, 32'h1);
      ahb(1'b0, CTRL_OFFSET, 32'h0);
      check("ctrl", rd, 32'h1);
      for (int c = 0; c < CHANNELS; c++) begin
         @(posedge clk);
         hold_neg <= 3'(1 << c);
         cycles(40);
         check("lane", 32'(pdata[c*DATA_BITS +: DATA_BITS]), 32'h0);
         ahb(1'b0, STATUS_OFFSET, 32'h0);
         check("neg flags", 32'(rd[STAT_NEG_LSB +: 3]), 32'(1 << c));
      end
      @(posedge clk);
      {hold_neg, run} <= 4'h0;
      cycles(70);
      check("lost data", 32'(pdata), 32'h0);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      check("lost lock", 32'(rd[STAT_CLK_OK_BIT +: 2]), 32'h0);
      @(posedge clk);
      run <= 1'b1;
      poll(1'b1);
      check("relock", 32'(rd[STAT_LOCKED_BIT]), 32'h1);
      @(posedge clk);
      period_ns <= 400;
      poll(1'b0);
      check("rate drop", 32'(rd[STAT_LOCKED_BIT]), 32'h0);
      poll(1'b1);
      ahb(1'b0, PERIOD_OFFSET, 32'h0);
      check("new period", rd, 32'(400 / CLK_PERIOD_NS));
      @(posedge clk);
      sleep_n <= 1'b0;
      cycles(4);
      check("data oe_n", 32'(poe_n), 32'h001f_ffff);
      check("strobe oe_n", 32'(strobe_oe_n), 32'h1);
      ahb(1'b0, STATUS_OFFSET, 32'h0);
      check("state", 32'(rd[1:0]), 32'(ST_SLEEP));
      // Sharing gap longer than 100 ns before enabling again
      cycles(3);
      @(posedge clk);
      sleep_n <= 1'b1;
      cycles(4);
      check("data oe_n", 32'(poe_n), 32'h0);
      check("data", 32'(pdata), 32'h0);
      poll(1'b1);
      check("wake lock", 32'(rd[STAT_LOCKED_BIT]), 32'h1);
      finish_test();
   end
endmodule
`default_nettype wire
